// File: include/mcs_pkg.sv
// Constants for the main clock select and prescaler block.
// Assumes a single 100 MHz system clock and an APB slave with 32-bit data.
package mcs_pkg;

    // Register indices; byte address is four times the index
    localparam logic [4:0] IDX_MAIN_SRC = 5'h00;
    localparam logic [4:0] IDX_PRESCALE = 5'h01;
    localparam logic [4:0] IDX_LOCK = 5'h02;
    localparam logic [4:0] IDX_STATE = 5'h03;
    localparam logic [4:0] IDX_FAST_CTL = 5'h10;
    localparam logic [4:0] IDX_TRIM_FREQ = 5'h11;
    localparam logic [4:0] IDX_TRIM_TEMP = 5'h12;
    localparam logic [4:0] IDX_LP_CTL = 5'h18;
    localparam logic [4:0] IDX_XTAL_CTL = 5'h1C;

    // Values after reset
    localparam logic [7:0] RST_MAIN_SRC = 8'h00;
    localparam logic [7:0] RST_PRESCALE = 8'h11;
    localparam logic [7:0] RST_FAST_CTL = 8'h00;
    localparam logic [7:0] RST_LP_CTL = 8'h00;
    localparam logic [7:0] RST_XTAL_CTL = 8'h00;
    localparam logic [6:0] RST_DIV = 7'h06; // Divisor in force after reset

    // Writable bits of each register
    localparam logic [7:0] MSK_MAIN_SRC = 8'h83;
    localparam logic [7:0] MSK_PRESCALE = 8'h1F;
    localparam logic [7:0] MSK_LOCK = 8'h01;
    localparam logic [7:0] MSK_RUN_SLEEP = 8'h02;
    localparam logic [7:0] MSK_TRIM_FREQ = 8'h7F;
    localparam logic [7:0] MSK_TRIM_TEMP = 8'h0F;
    localparam logic [7:0] MSK_XTAL_CTL = 8'h37;

    // Field positions
    localparam int unsigned POS_CLK_PIN = 7;
    localparam int unsigned POS_SRC_LSB = 0;
    localparam int unsigned POS_DIV_LSB = 1;
    localparam int unsigned POS_PEN = 0;
    localparam int unsigned POS_LOCK = 0;
    localparam int unsigned POS_FUSE_LOCK = 7;
    localparam int unsigned POS_SWITCHING = 0;
    localparam int unsigned POS_STABLE_LSB = 4;

    // Source codes
    localparam logic [1:0] SRC_FAST_RC = 2'h0;
    localparam logic [1:0] SRC_LP_RC = 2'h1;
    localparam logic [1:0] SRC_CRYSTAL = 2'h2;
    localparam logic [1:0] SRC_EXTERNAL = 2'h3;

    // Instructions the unlock window stays open
    localparam logic [2:0] UNLOCK_INSTR = 3'h4;

    // Divisor for a divide code; reserved codes fall back to 2
    function automatic logic [6:0] div_of(input logic [3:0] code);
        logic [6:0] d;
        d = 7'h02;
        case (code)
            4'h0: d = 7'h02;
            4'h1: d = 7'h04;
            4'h2: d = 7'h08;
            4'h3: d = 7'h10;
            4'h4: d = 7'h20;
            4'h5: d = 7'h40;
            4'h8: d = 7'h06;
            4'h9: d = 7'h0A;
            4'hA: d = 7'h0C;
            4'hB: d = 7'h18;
            4'hC: d = 7'h30;
            default: d = 7'h02;
        endcase
        return d;
    endfunction : div_of

endpackage : mcs_pkg

// File: design/mcs_main_clock.sv
// Main clock select, prescaler, clock pin and guarded register file.
// Assumes oscillator levels and stable flags arrive from other domains,
// and CPU key/instruction strobes come from logic on clk.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps

// Summary of operation
// - Guarded write needs key, then within four instructions
// - Unguarded write to guarded register changes nothing
// - Guard covers all eight control registers
// - Clock pin bit drives main clock out
// - No pin clock in sleep unless peripheral uses
// - Select code picks one of four sources
// - Divide codes map to documented divisors
// - Divide code bits 4:1, enable bit 0
// - Divide code writable while running
// - Enable bit set turns prescaler on
// - Enable clear gives peripheral clock equal main
// - Reset gives fast oscillator, divide by six
// - Lock bit freezes main registers until reset
// - Switching flag while pending; move once stable
module mcs_main_clock #(
    parameter int unsigned AW = 12 // APB address width
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU side
    input wire logic unlock_key_stb,
    input wire logic instr_stb,
    input wire logic sleep,
    input wire logic periph_busy,
    // Fuse values, caught after reset release
    input wire logic fuse_lock,
    input wire logic [6:0] fuse_trim_freq,
    input wire logic [3:0] fuse_trim_temp,
    // Oscillator levels and stable flags, order fast, lp, crystal, external
    input wire logic [3:0] src_level,
    input wire logic [3:0] src_stable,
    // Clocks out
    output logic main_clk,
    output logic peripheral_clock,
    output logic clk_pin
);

    // Refuse narrow buses at elaboration; the highest register sits at byte 0x70,
    // so fewer than seven address bits would alias registers onto each other
    if (AW < 7) begin : g_aw_check
        $error("mcs_main_clock: AW must be at least 7");
    end
    // Bits of paddr above bit 6 are ignored by the decode below

    // Whole state of the block
    typedef struct packed {
        logic [7:0] main_src;     // Clock pin bit and source select
        logic [7:0] prescale;     // Divide code and enable
        logic lock;               // Main config lock bit
        logic [7:0] fast_ctl;     // Fast oscillator keep-running
        logic [7:0] trim_freq;    // Fast oscillator frequency trim
        logic [3:0] trim_temp;    // Fast oscillator temperature trim
        logic fuse_lk;            // Trim locked by fuse
        logic [7:0] lp_ctl;       // Low-power oscillator keep-running
        logic [7:0] xtal_ctl;     // Crystal control
        logic fuse_pend;          // Fuse values still to be caught
        logic [2:0] win;          // Instructions left in unlock window
        logic [7:0] sy1;          // Synchroniser stage one
        logic [7:0] sy2;          // Synchroniser stage two
        logic [7:0] sy3;          // Synchroniser stage three
        logic [7:0] flt;          // Agreed levels and stable flags
        logic [1:0] act_src;      // Source now feeding the main clock
        logic main_lvl;           // Main clock level
        logic [6:0] div_act;      // Divisor in force, 1 when bypassed
        logic [5:0] cnt;          // Main clock rises in this period
        logic periph_lvl;         // Peripheral clock level
        logic pin_lvl;            // Clock pin level
        logic rdy;                // APB ready
        logic [31:0] rdata;       // APB read data
        logic err;                // APB error
    } mcs_state_t;

    mcs_state_t s_r;
    mcs_state_t s_nxt;

    // Address decode and bus strobes
    logic [4:0] idx;
    logic mapped;
    logic access;
    logic commit;
    logic wr;
    logic open_win;
    logic main_wr_ok;
    logic trim_wr_ok;
    logic [7:0] wdat;
    logic [7:0] rd_byte;
    logic [7:0] status;
    logic switching;
    logic new_lvl;
    logic main_rise;
    logic [6:0] next_div;
    logic [5:0] next_cnt;

    assign idx = paddr[6:2];
    assign wdat = pwdata[7:0];
    assign access = psel && penable;
    assign commit = access && s_r.rdy;
    assign wr = commit && pwrite;
    assign open_win = (s_r.win != 3'h0);
    // Main registers refuse writes once locked
    assign main_wr_ok = open_win && !s_r.lock;
    // Trim is frozen by fuse, or by lock while the fast oscillator runs main
    assign trim_wr_ok = open_win && !s_r.fuse_lk
        && !(s_r.lock && s_r.act_src == mcs_pkg::SRC_FAST_RC);
    assign switching = (s_r.main_src[1:0] != s_r.act_src);
    assign status = {s_r.flt[7:4], 3'h0, switching};

    // Mapped addresses and read mux
    always_comb begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        unique case (idx)
            mcs_pkg::IDX_MAIN_SRC: rd_byte = s_r.main_src;
            mcs_pkg::IDX_PRESCALE: rd_byte = s_r.prescale;
            mcs_pkg::IDX_LOCK: rd_byte = {7'h00, s_r.lock};
            mcs_pkg::IDX_STATE: rd_byte = status;
            mcs_pkg::IDX_FAST_CTL: rd_byte = s_r.fast_ctl;
            mcs_pkg::IDX_TRIM_FREQ: rd_byte = s_r.trim_freq;
            mcs_pkg::IDX_TRIM_TEMP: rd_byte = {s_r.fuse_lk, 3'h0, s_r.trim_temp};
            mcs_pkg::IDX_LP_CTL: rd_byte = s_r.lp_ctl;
            mcs_pkg::IDX_XTAL_CTL: rd_byte = s_r.xtal_ctl;
            default: mapped = 1'b0;
        endcase
    end

    // Next state of the whole block
    always_comb begin
        s_nxt = s_r;
        new_lvl = 1'b0;
        main_rise = 1'b0;
        next_div = s_r.div_act;
        next_cnt = s_r.cnt;
        // APB answer one cycle into the access phase
        s_nxt.rdy = access && !s_r.rdy;
        s_nxt.err = access && !s_r.rdy && !mapped;
        if (access && !s_r.rdy) begin
            s_nxt.rdata = {24'h000000, rd_byte};
        end
        // Fuse values caught once reset has gone
        if (s_r.fuse_pend) begin
            s_nxt.fuse_pend = 1'b0;
            s_nxt.lock = fuse_lock;
            s_nxt.fuse_lk = fuse_lock;
            s_nxt.trim_freq = {1'b0, fuse_trim_freq};
            s_nxt.trim_temp = fuse_trim_temp;
        end
        // Unlock window counts down on instructions
        if (instr_stb && open_win) begin
            s_nxt.win = s_r.win - 3'h1;
        end
        // Guarded writes; anything outside the window is dropped
        if (wr && mapped && open_win) begin
            s_nxt.win = 3'h0;
            unique case (idx)
                mcs_pkg::IDX_MAIN_SRC: begin
                    if (main_wr_ok) begin
                        s_nxt.main_src = wdat & mcs_pkg::MSK_MAIN_SRC;
                    end
                end
                mcs_pkg::IDX_PRESCALE: begin
                    if (main_wr_ok) begin
                        s_nxt.prescale = wdat & mcs_pkg::MSK_PRESCALE;
                    end
                end
                mcs_pkg::IDX_LOCK: begin
                    if (main_wr_ok) begin
                        s_nxt.lock = wdat[mcs_pkg::POS_LOCK];
                    end
                end
                mcs_pkg::IDX_FAST_CTL: s_nxt.fast_ctl = wdat & mcs_pkg::MSK_RUN_SLEEP;
                mcs_pkg::IDX_TRIM_FREQ: begin
                    if (trim_wr_ok) begin
                        s_nxt.trim_freq = wdat & mcs_pkg::MSK_TRIM_FREQ;
                    end
                end
                mcs_pkg::IDX_TRIM_TEMP: begin
                    if (trim_wr_ok) begin
                        s_nxt.trim_temp = wdat[3:0];
                    end
                end
                mcs_pkg::IDX_LP_CTL: s_nxt.lp_ctl = wdat & mcs_pkg::MSK_RUN_SLEEP;
                mcs_pkg::IDX_XTAL_CTL: s_nxt.xtal_ctl = wdat & mcs_pkg::MSK_XTAL_CTL;
                default: s_nxt.win = 3'h0;
            endcase
        end
        // A fresh key reopens the window, later than any countdown
        if (unlock_key_stb) begin
            s_nxt.win = mcs_pkg::UNLOCK_INSTR;
        end
        // Three-stage sync; a change counts when stages two and three agree
        s_nxt.sy1 = {src_stable, src_level};
        s_nxt.sy2 = s_r.sy1;
        s_nxt.sy3 = s_r.sy2;
        for (int i = 0; i < 8; i++) begin
            if (s_r.sy2[i] == s_r.sy3[i]) begin
                s_nxt.flt[i] = s_r.sy3[i];
            end
        end
        // Move source only once new one is stable and both clocks are low,
        // so no stretched or shortened pulse reaches the main clock
        if (switching && s_r.flt[4 + s_r.main_src[1:0]]
            && !s_r.main_lvl && !s_r.flt[s_r.main_src[1:0]]) begin
            s_nxt.act_src = s_r.main_src[1:0];
        end
        new_lvl = s_nxt.act_src == s_r.act_src ? s_r.flt[s_r.act_src] : 1'b0;
        s_nxt.main_lvl = new_lvl;
        main_rise = new_lvl && !s_r.main_lvl;
        // Divider reloads only at a period boundary, never mid-pulse
        if (main_rise) begin
            if ({1'b0, s_r.cnt} >= s_r.div_act - 7'h01) begin
                next_cnt = 6'h00;
                next_div = s_r.prescale[mcs_pkg::POS_PEN]
                    ? mcs_pkg::div_of(s_r.prescale[4:1]) : 7'h01;
            end else begin
                next_cnt = s_r.cnt + 6'h01;
            end
        end
        s_nxt.cnt = next_cnt;
        s_nxt.div_act = next_div;
        // Bypass follows main; divided clock is high for the first half
        if (next_div == 7'h01) begin
            s_nxt.periph_lvl = new_lvl;
        end else begin
            s_nxt.periph_lvl = {1'b0, next_cnt} < (next_div >> 1);
        end
        // Clock pin carries main clock, silenced in idle sleep
        s_nxt.pin_lvl = s_r.main_src[mcs_pkg::POS_CLK_PIN]
            && (!sleep || periph_busy) && new_lvl;
    end

    // State register with synchronous reset and clock enable
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.main_src <= mcs_pkg::RST_MAIN_SRC;
            s_r.prescale <= mcs_pkg::RST_PRESCALE;
            s_r.fast_ctl <= mcs_pkg::RST_FAST_CTL;
            s_r.lp_ctl <= mcs_pkg::RST_LP_CTL;
            s_r.xtal_ctl <= mcs_pkg::RST_XTAL_CTL;
            s_r.fuse_pend <= 1'b1;
            s_r.act_src <= mcs_pkg::SRC_FAST_RC;
            s_r.div_act <= mcs_pkg::RST_DIV;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign prdata = s_r.rdata;
    assign pready = s_r.rdy;
    assign pslverr = s_r.err;
    assign main_clk = s_r.main_lvl;
    assign peripheral_clock = s_r.periph_lvl;
    assign clk_pin = s_r.pin_lvl;

    // Checks on the logic above
    sequence s_closed_write;
        ce && wr && s_r.win == 3'h0 && idx == mcs_pkg::IDX_PRESCALE;
    endsequence

    sequence s_last_instr;
        ce && instr_stb && !unlock_key_stb && s_r.win == 3'h1;
    endsequence

    property p_closed_write;
        @(posedge clk) disable iff (rst) s_closed_write |=> $stable(s_r.prescale);
    endproperty
    a_closed_write: assert property (p_closed_write)
        else $error("guarded write took effect with window closed");

    property p_key_opens;
        @(posedge clk) disable iff (rst)
            ce && unlock_key_stb |=> s_r.win == 3'h4;
    endproperty
    a_key_opens: assert property (p_key_opens)
        else $error("unlock key did not open a four instruction window");

    property p_window_ends;
        @(posedge clk) disable iff (rst) s_last_instr |=> s_r.win == 3'h0;
    endproperty
    a_window_ends: assert property (p_window_ends)
        else $error("unlock window still open after fourth instruction");

    property p_locked;
        @(posedge clk) disable iff (rst)
            s_r.lock && !s_r.fuse_pend |=> s_r.lock && $stable(s_r.main_src);
    endproperty
    a_locked: assert property (p_locked)
        else $error("locked main registers changed");

    property p_pin_needs_bit;
        @(posedge clk) disable iff (rst)
            s_r.pin_lvl |-> $past(s_r.main_src[7]) && s_r.main_lvl;
    endproperty
    a_pin_needs_bit: assert property (p_pin_needs_bit)
        else $error("clock pin active without its enable bit");

    property p_sleep_quiet;
        @(posedge clk) disable iff (rst)
            ce && sleep && !periph_busy |=> !s_r.pin_lvl;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("clock pin toggled in idle sleep");

    property p_switch_safe;
        @(posedge clk) disable iff (rst)
            $changed(s_r.act_src) |-> !$past(s_r.main_lvl) && !s_r.main_lvl
                && $past(s_r.flt[4 + s_r.main_src[1:0]]);
    endproperty
    a_switch_safe: assert property (p_switch_safe)
        else $error("source moved while unstable or mid-pulse");

    property p_bypass;
        @(posedge clk) disable iff (rst)
            s_r.div_act == 7'h01 |-> s_r.periph_lvl == s_r.main_lvl;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypassed peripheral clock differs from main");

    property p_div_load;
        @(posedge clk) disable iff (rst)
            $changed(s_r.div_act) && $past(s_r.prescale[0]) |->
                s_r.div_act == mcs_pkg::div_of($past(s_r.prescale[4:1]));
    endproperty
    a_div_load: assert property (p_div_load)
        else $error("divisor does not match divide code");

    property p_reset_state;
        @(posedge clk) $past(rst) && !rst |->
            s_r.prescale == mcs_pkg::RST_PRESCALE && s_r.act_src == mcs_pkg::SRC_FAST_RC
                && s_r.div_act == mcs_pkg::RST_DIV;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset did not select fast oscillator divided by six");

endmodule : mcs_main_clock

// File: dv/mcs_main_clock_tb_top.sv
// Self-checking bench for the main clock select and prescaler block.
// Assumes the design's APB slave and package, and one 100 MHz clock.
`timescale 1ns/10ps
module mcs_main_clock_tb_top;
    // Clock, reset, enable
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    // APB master side
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr;
    // CPU strobes and sleep levels
    logic unlock_key_stb = 1'b0, instr_stb = 1'b0, sleep = 1'b0, periph_busy = 1'b0;
    // Fuses and oscillator stand-ins
    logic fuse_lock = 1'b0;
    logic [6:0] fuse_trim_freq = 7'h35;
    logic [3:0] fuse_trim_temp = 4'hA;
    logic [3:0] src_level = 4'h0;
    logic [3:0] src_stable = 4'h1;
    logic main_clk, peripheral_clock, clk_pin;
    // Score and oscillator counter
    int fail_count = 0, checks = 0, osc_cnt = 0;
    // Guarded registers, reset readings, masks seen after writing all ones
    logic [4:0] gidx [8] = '{mcs_pkg::IDX_MAIN_SRC, mcs_pkg::IDX_PRESCALE, mcs_pkg::IDX_LOCK,
        mcs_pkg::IDX_FAST_CTL, mcs_pkg::IDX_TRIM_FREQ, mcs_pkg::IDX_TRIM_TEMP,
        mcs_pkg::IDX_LP_CTL, mcs_pkg::IDX_XTAL_CTL};
    logic [7:0] gval [8] = '{8'h00, 8'h11, 8'h00, 8'h00, 8'h35, 8'h0A, 8'h00, 8'h00};
    logic [7:0] gmsk [8] = '{8'h00, 8'h00, 8'h00, mcs_pkg::MSK_RUN_SLEEP, mcs_pkg::MSK_TRIM_FREQ,
        mcs_pkg::MSK_TRIM_TEMP, mcs_pkg::MSK_RUN_SLEEP, mcs_pkg::MSK_XTAL_CTL};
    // Divide codes and their divisors
    logic [3:0] dcode [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
    int dexp [11] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
    // Source order and main periods in clk cycles
    logic [1:0] ssel [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int sper [4] = '{16, 12, 20, 8};

    // Free-running clock
    always #5 clk = ~clk;

    // Square waves slow enough for the 3-flop filter; periods 8, 16, 12, 20
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 1;
        src_level <= {(osc_cnt % 20) < 10, (osc_cnt % 12) < 6, (osc_cnt % 16) < 8,
            (osc_cnt % 8) < 4};
    end

    // Device under test
    mcs_main_clock #(.AW(12)) u_mcs_main_clock (
        .clk(clk), .rst(rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .unlock_key_stb(unlock_key_stb), .instr_stb(instr_stb), .sleep(sleep),
        .periph_busy(periph_busy), .fuse_lock(fuse_lock), .fuse_trim_freq(fuse_trim_freq),
        .fuse_trim_temp(fuse_trim_temp), .src_level(src_level), .src_stable(src_stable),
        .main_clk(main_clk), .peripheral_clock(peripheral_clock), .clk_pin(clk_pin)
    );

    // Single comparison point
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [4:0] idx, input logic [7:0] wd,
        output logic [7:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {5'h00, idx, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata[7:0];
        err = pslverr;
        if (pready !== 1'b1) chk(32'h0, 32'h1, "pready missing");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Plain write and checked read
    task automatic wr(input logic [4:0] idx, input logic [7:0] wd);
        logic [7:0] rd;
        logic e;
        apb(1'b1, idx, wd, rd, e);
    endtask : wr

    task automatic rdchk(input logic [4:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] rd;
        logic e;
        apb(1'b0, idx, 8'h00, rd, e);
        chk({24'h000000, rd}, {24'h000000, exp}, what);
        chk({31'h00000000, e}, 32'h00000000, "mapped error");
    endtask : rdchk

    // Unlock key, ni retired instructions, then the write
    task automatic gw(input logic [4:0] idx, input logic [7:0] wd, input int ni);
        @(posedge clk);
        unlock_key_stb <= 1'b1;
        @(posedge clk);
        unlock_key_stb <= 1'b0;
        repeat (ni) begin
            @(posedge clk);
            instr_stb <= 1'b1;
        end
        @(posedge clk);
        instr_stb <= 1'b0;
        wr(idx, wd);
    endtask : gw

    // From one rise of the watched clock to the next: clk cycles and main rises
    task automatic measure(input bit per, output int cyc, output int mains);
        logic pm, pt, cm, ct;
        int n, seen;
        seen = 0;
        cyc = 0;
        mains = 0;
        pm = main_clk;
        pt = per ? peripheral_clock : main_clk;
        for (n = 0; n < 3000 && seen < 2; n++) begin
            @(posedge clk);
            cm = main_clk;
            ct = per ? peripheral_clock : main_clk;
            if (seen == 1) begin
                cyc++;
                if (cm && !pm) mains++;
            end
            if (ct && !pt) seen++;
            pm = cm;
            pt = ct;
        end
        if (seen < 2) chk(32'h0, 32'h1, "clock stalled");
    endtask : measure

    // Pin rises over 96 cycles, i.e. twelve periods of the fast source
    task automatic pin_rises(output int r);
        logic prev;
        repeat (4) @(posedge clk);
        r = 0;
        prev = clk_pin;
        repeat (96) begin
            @(posedge clk);
            if (clk_pin && !prev) r++;
            prev = clk_pin;
        end
    endtask : pin_rises

    // Synchronous reset held for 8 cycles
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    // Single exit point
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // Watchdog well beyond the roughly 9000 cycles the tests need
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end

    // Main sequence
    initial begin
        logic [7:0] rd;
        logic e;
        int c, m, k, i, prevp;
        do_reset();
        for (i = 0; i < 8; i++) rdchk(gidx[i], gval[i], "reset value");
        apb(1'b0, 5'h04, 8'h00, rd, e);
        chk(32'(e), 32'h1, "unmapped error");
        end_test("reset");
        // Writes without the key change nothing
        for (i = 0; i < 8; i++) wr(gidx[i], 8'hFF);
        for (i = 0; i < 8; i++) rdchk(gidx[i], gval[i], "unguarded");
        gw(mcs_pkg::IDX_PRESCALE, 8'h03, 3);
        rdchk(mcs_pkg::IDX_PRESCALE, 8'h03, "three instr");
        gw(mcs_pkg::IDX_PRESCALE, 8'h05, 4);
        rdchk(mcs_pkg::IDX_PRESCALE, 8'h03, "four instr");
        gw(mcs_pkg::IDX_PRESCALE, 8'h05, 0);
        wr(mcs_pkg::IDX_PRESCALE, 8'h07);
        rdchk(mcs_pkg::IDX_PRESCALE, 8'h05, "second write");
        for (i = 3; i < 8; i++) begin
            gw(gidx[i], 8'hFF, 2);
            rdchk(gidx[i], gmsk[i], "guarded");
        end
        end_test("guard");
        // Every documented divide code, changed while running
        for (i = 0; i < 11; i++) begin
            gw(mcs_pkg::IDX_PRESCALE, {3'h0, dcode[i], 1'b1}, 0);
            measure(1'b1, c, m);
            measure(1'b1, c, m);
            chk(32'(m), 32'(dexp[i]), "divide ratio");
        end
        gw(mcs_pkg::IDX_PRESCALE, 8'h0A, 0);
        measure(1'b1, c, m);
        measure(1'b1, c, m);
        chk(32'(m), 32'h1, "undivided");
        end_test("prescaler");
        // Source switching waits for the stable flag
        prevp = 8;
        for (i = 0; i < 4; i++) begin
            gw(mcs_pkg::IDX_MAIN_SRC, {6'h00, ssel[i]}, 0);
            if (ssel[i] != 2'h0) begin
                apb(1'b0, mcs_pkg::IDX_STATE, 8'h00, rd, e);
                chk(32'(rd[0]), 32'h1, "switch pending");
                measure(1'b0, c, m);
                chk(32'(c), 32'(prevp), "old source kept");
                src_stable[ssel[i]] <= 1'b1;
            end
            k = 0;
            do begin
                apb(1'b0, mcs_pkg::IDX_STATE, 8'h00, rd, e);
                k++;
            end while (rd[0] !== 1'b0 && k < 40);
            chk(32'(rd[0]), 32'h0, "switch done");
            measure(1'b0, c, m);
            measure(1'b0, c, m);
            chk(32'(c), 32'(sper[i]), "main period");
            prevp = sper[i];
        end
        rdchk(mcs_pkg::IDX_STATE, 8'hF0, "stable flags");
        end_test("source");
        // Clock pin, awake and asleep
        pin_rises(k);
        chk(32'(k), 32'h0, "pin off");
        gw(mcs_pkg::IDX_MAIN_SRC, 8'h80, 0);
        pin_rises(k);
        chk(32'(k), 32'd12, "pin on");
        sleep <= 1'b1;
        pin_rises(k);
        chk(32'(k), 32'h0, "pin asleep");
        periph_busy <= 1'b1;
        pin_rises(k);
        chk(32'(k), 32'd12, "pin asleep busy");
        sleep <= 1'b0;
        periph_busy <= 1'b0;
        end_test("pin");
        // Lock freezes main registers and trim
        gw(mcs_pkg::IDX_LOCK, 8'h01, 1);
        rdchk(mcs_pkg::IDX_LOCK, 8'h01, "lock set");
        gw(mcs_pkg::IDX_PRESCALE, 8'h10, 0);
        rdchk(mcs_pkg::IDX_PRESCALE, 8'h0A, "locked div");
        gw(mcs_pkg::IDX_MAIN_SRC, 8'h01, 0);
        rdchk(mcs_pkg::IDX_MAIN_SRC, 8'h80, "locked src");
        gw(mcs_pkg::IDX_LOCK, 8'h00, 0);
        rdchk(mcs_pkg::IDX_LOCK, 8'h01, "locked lock");
        gw(mcs_pkg::IDX_TRIM_FREQ, 8'h00, 0);
        rdchk(mcs_pkg::IDX_TRIM_FREQ, 8'h7F, "locked trim");
        end_test("lock");
        // Second reset with the fuse lock set
        fuse_lock <= 1'b1;
        do_reset();
        rdchk(mcs_pkg::IDX_LOCK, 8'h01, "fuse lock");
        rdchk(mcs_pkg::IDX_TRIM_TEMP, 8'h8A, "fuse trim");
        rdchk(mcs_pkg::IDX_MAIN_SRC, mcs_pkg::RST_MAIN_SRC, "src again");
        rdchk(mcs_pkg::IDX_PRESCALE, mcs_pkg::RST_PRESCALE, "div again");
        measure(1'b0, c, m);
        chk(32'(c), 32'd8, "fast source");
        measure(1'b1, c, m);
        measure(1'b1, c, m);
        chk(32'(m), 32'd6, "divide by six");
        end_test("second reset");
        give_verdict();
    end
endmodule : mcs_main_clock_tb_top
